// ==== src/hpp_device.sv ====
// Device end of the host parallel port with its two word FIFOs
// Behaviour
// - 8-bit slave port, all controls are inputs
// - Split strobes or shared strobe plus direction
// - Host sends at most one byte per three clocks
// - Handshake and data strobe polarity are programmable
// - Receive and transmit FIFOs, 16 by 64
// - Words move as byte pairs, commit on second
// - Upper byte goes first in each pair
// - Processor write to full transmit FIFO dropped
// - Host never writes while receive FIFO full
// - Deselected port releases bus, ignores strobes
// - Status bit 11 means transmit FIFO not full
// - Status bit 10 means receive FIFO not empty
// - Bit 1 transmit empty, bit 0 receive full
// - Port status is read only
// - Split read starts on select and read low
// - Read end flags empty transmit FIFO
// - Split write samples bus every clock
// - Write end flags full receive FIFO
// - Strobes treated as asynchronous to clock
// - External receive full indication for host
// - Handshake output is OR of both flags
// - Shared mode direction high reads, low writes
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module hpp_fifo #(
  parameter int W = 16,
  parameter int D = 64
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Fill side
  input  wire logic                   push,
  input  wire logic [W-1:0]           wdata,
  // Drain side
  input  wire logic                   pop,
  output logic      [W-1:0]           head,
  output logic      [$clog2(D):0]     count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic          do_push;
  logic          do_pop;

  assign do_push = push && (count != (AW+1)'(D));
  assign do_pop  = pop && (count != '0);
  assign head    = mem[rptr];

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wptr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
        wptr <= (wptr == AW'(D - 1)) ? '0 : wptr + 1'b1;
      if (do_pop)
        rptr <= (rptr == AW'(D - 1)) ? '0 : rptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

module hpp_device #(
  parameter int DEPTH = hpp_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Host link
  hpp_if.device            link,
  // Configuration
  input  wire logic        cfg_shared_mode,
  input  wire logic        cfg_ds_active_high,
  input  wire logic        cfg_hs_active_high,
  // Processor transmit side
  input  wire logic        tx_write,
  input  wire logic [15:0] tx_wdata,
  // Processor receive side
  input  wire logic        rx_read,
  output logic      [15:0] rx_rdata,
  // Status
  output logic      [15:0] port_status
);
  localparam int CW = $clog2(DEPTH) + 1;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  logic [7:0] bus_s1;
  logic [7:0] bus_s2;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctl_s1 <= 3'h7;
      ctl_s2 <= 3'h7;
      bus_s1 <= 8'h00;
      bus_s2 <= 8'h00;
    end
    else
    begin
      ctl_s1 <= {link.host_write_strobe_n, link.host_read_strobe_n, link.host_select_n};
      ctl_s2 <= ctl_s1;
      bus_s1 <= link.host_byte_bus;
      bus_s2 <= bus_s1;
    end
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic cs_on;
  logic ds_on;
  logic rd_on;
  logic wr_on;
  logic rd_q;
  logic wr_q;
  logic rd_end;
  logic wr_end;

  assign cs_on = !ctl_s2[0];
  assign ds_on = cfg_ds_active_high ? ctl_s2[1] : !ctl_s2[1];

  always_comb
  begin
    if (cfg_shared_mode)
    begin
      rd_on = cs_on && ds_on && ctl_s2[2];
      wr_on = cs_on && ds_on && !ctl_s2[2];
    end
    else
    begin
      rd_on = cs_on && !ctl_s2[1];
      wr_on = cs_on && !ctl_s2[2];
    end
  end

  assign rd_end = rd_q && !rd_on;
  assign wr_end = wr_q && !wr_on;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_on;
      wr_q <= wr_on;
    end
  end

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  logic          rx_push;
  logic [15:0]   rx_word;
  logic [15:0]   rx_head;
  logic [CW-1:0] rx_count;
  logic          tx_pop;
  logic [15:0]   tx_head;
  logic [CW-1:0] tx_count;

  hpp_fifo #(.W(hpp_pkg::WORD_W), .D(DEPTH)) u_rx_fifo
  (
    .clk    (clk),
    .resetn (resetn),
    .push   (rx_push),
    .wdata  (rx_word),
    .pop    (rx_read),
    .head   (rx_head),
    .count  (rx_count)
  );

  hpp_fifo #(.W(hpp_pkg::WORD_W), .D(DEPTH)) u_tx_fifo
  (
    .clk    (clk),
    .resetn (resetn),
    .push   (tx_write),
    .wdata  (tx_wdata),
    .pop    (tx_pop),
    .head   (tx_head),
    .count  (tx_count)
  );

  // ----------------------------------------
  // Host write path
  // ----------------------------------------
  logic [7:0] rx_byte;
  logic [7:0] rx_upper;
  logic       rx_phase;

  assign rx_word = {rx_upper, rx_byte};
  assign rx_push = wr_end && rx_phase;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_byte  <= 8'h00;
      rx_upper <= 8'h00;
      rx_phase <= 1'b0;
    end
    else
    begin
      if (wr_on)
        rx_byte <= bus_s2;
      if (wr_end)
      begin
        rx_phase <= !rx_phase;
        if (!rx_phase)
          rx_upper <= rx_byte;
      end
    end
  end

  // ----------------------------------------
  // Host read path
  // ----------------------------------------
  logic tx_phase;

  assign tx_pop = rd_end && tx_phase;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      tx_phase <= 1'b0;
    else if (rd_end)
      tx_phase <= !tx_phase;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.dev_byte_out <= 8'h00;
      link.dev_byte_oe  <= 1'b0;
    end
    else
    begin
      link.dev_byte_out <= tx_phase ? tx_head[7:0] : tx_head[15:8];
      link.dev_byte_oe  <= rd_on;
    end
  end

  // ----------------------------------------
  // Buffer flags and handshake
  // ----------------------------------------
  logic tx_empty_flag;
  logic rx_full_indicator;
  logic tx_empty_after;
  logic rx_full_after;

  assign tx_empty_after = (tx_count == '0) || (tx_pop && tx_count == CW'(1));
  assign rx_full_after  = (rx_count == CW'(DEPTH)) || (rx_push && rx_count == CW'(DEPTH - 1));

  always_ff @(posedge clk)
  begin
    if (!resetn)
      tx_empty_flag <= 1'b0;
    else if (rd_end && tx_empty_after)
      tx_empty_flag <= 1'b1;
    else if (tx_write)
      tx_empty_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      rx_full_indicator <= 1'b0;
    else if (wr_end && rx_full_after)
      rx_full_indicator <= 1'b1;
    else if (rx_read)
      rx_full_indicator <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      link.handshake_status_out <= !cfg_hs_active_high ? 1'b1 : 1'b0;
    else
      link.handshake_status_out <= (rx_full_indicator || tx_empty_flag) ^ !cfg_hs_active_high;
  end

  // ----------------------------------------
  // Processor view
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      port_status <= 16'h0000;
      rx_rdata    <= 16'h0000;
    end
    else
    begin
      port_status                       <= 16'h0000;
      port_status[hpp_pkg::ST_TX_NFULL] <= (tx_count != CW'(DEPTH));
      port_status[hpp_pkg::ST_RX_NEMPT] <= (rx_count != '0);
      port_status[hpp_pkg::ST_TX_EMPTY] <= tx_empty_flag;
      port_status[hpp_pkg::ST_RX_FULL]  <= rx_full_indicator;
      rx_rdata                          <= rx_head;
    end
  end
endmodule

// ==== src/hpp_pkg.sv ====
// Shared constants for the host parallel port device and host ends
package hpp_pkg;
  // ----------------------------------------
  // Data widths and buffer depth
  // ----------------------------------------
  localparam int BYTE_W     = 8;
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 64;
  // ----------------------------------------
  // Port status bit positions
  // ----------------------------------------
  localparam int ST_W        = 16;
  localparam int ST_TX_NFULL = 11;
  localparam int ST_RX_NEMPT = 10;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_FULL  = 0;
  // ----------------------------------------
  // Host register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_SHARED    = 0;
  localparam int CTRL_DS_HIGH   = 1;
  localparam int CTRL_HS_HIGH   = 2;
  localparam int CMD_READ       = 0;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_HS        = 1;
  localparam int STAT_RX_VALID  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ    = 125;
  localparam int STROBE_NS  = 64;
  localparam int GAP_NS     = 64;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC    = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] BUS_IDLE = 8'hff;
  // ----------------------------------------
  // Host sequencer states
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    HPP_IDLE = 3'b001,
    HPP_ACT  = 3'b010,
    HPP_GAP  = 3'b100
  } hpp_state_t;
endpackage

// ==== src/hpp_if.sv ====
// Byte bus link between the host and device ends
`timescale 1ns/1ps
interface hpp_if;
  logic       host_select_n;
  logic       host_read_strobe_n;
  logic       host_write_strobe_n;
  logic [7:0] host_byte_out;
  logic       host_byte_oe;
  logic [7:0] dev_byte_out;
  logic       dev_byte_oe;
  logic [7:0] host_byte_bus;
  logic       handshake_status_out;

  // Resolved bus level, pulled high when nobody drives it
  assign host_byte_bus = dev_byte_oe ? dev_byte_out : (host_byte_oe ? host_byte_out : hpp_pkg::BUS_IDLE);

  modport device
  (
    input  host_select_n,
    input  host_read_strobe_n,
    input  host_write_strobe_n,
    input  host_byte_bus,
    output dev_byte_out,
    output dev_byte_oe,
    output handshake_status_out
  );

  modport host
  (
    output host_select_n,
    output host_read_strobe_n,
    output host_write_strobe_n,
    output host_byte_out,
    output host_byte_oe,
    input  host_byte_bus,
    input  handshake_status_out
  );
endinterface

// ==== src/hpp_host.sv ====
// Host end of the parallel port, driven from AHB-Lite registers
`timescale 1ns/1ps
module hpp_host
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Device link
  hpp_if.host              link,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp
);
  localparam int CNT_W = 8;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [8:0] in_s1;
  logic [8:0] in_s2;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      in_s1 <= 9'h000;
      in_s2 <= 9'h000;
    end
    else
    begin
      in_s1 <= {link.handshake_status_out, link.host_byte_bus};
      in_s2 <= in_s1;
    end
  end

  // ----------------------------------------
  // AHB-Lite register access
  // ----------------------------------------
  logic [2:0]  ctrl;
  logic [15:0] rx_word;
  logic        rx_valid;
  logic        busy;
  logic        hs_on;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_ok;
  logic        start_write;
  logic        start_read;
  logic        rx_taken;

  assign addr_ok     = hsel && hready && (htrans == hpp_pkg::HTRANS_NONSEQ);
  assign start_write = wr_pend && (wr_addr == hpp_pkg::REG_TXDATA) && !busy;
  assign start_read  = wr_pend && (wr_addr == hpp_pkg::REG_CMD) && hwdata[hpp_pkg::CMD_READ] && !busy;
  assign rx_taken    = addr_ok && !hwrite && (haddr[7:0] == hpp_pkg::REG_RXDATA);
  assign hs_on       = in_s2[8] ^ !ctrl[hpp_pkg::CTRL_HS_HIGH];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      hrdata  <= 32'h0000_0000;
      if (addr_ok && !hwrite)
      begin
        unique case (haddr[7:0])
          hpp_pkg::REG_CTRL:   hrdata <= {29'h0, ctrl};
          hpp_pkg::REG_RXDATA: hrdata <= {16'h0, rx_word};
          hpp_pkg::REG_STATUS: hrdata <= {29'h0, rx_valid, hs_on, busy};
          default:             hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ctrl <= hpp_pkg::CTRL_RESET;
    else if (wr_pend && wr_addr == hpp_pkg::REG_CTRL && !busy)
      ctrl <= hwdata[2:0];
  end

  // ----------------------------------------
  // Byte sequencer
  // ----------------------------------------
  hpp_pkg::hpp_state_t state;
  hpp_pkg::hpp_state_t next_state;
  logic [CNT_W-1:0]    cnt;
  logic                byte_idx;
  logic                dir_read;
  logic [15:0]         tx_word;
  logic                cnt_done;

  assign cnt_done = (cnt == '0);
  assign busy     = (state != hpp_pkg::HPP_IDLE);

  always_comb
  begin
    next_state = state;
    unique case (state)
      hpp_pkg::HPP_IDLE: if (start_write || start_read) next_state = hpp_pkg::HPP_ACT;
      hpp_pkg::HPP_ACT:  if (cnt_done) next_state = hpp_pkg::HPP_GAP;
      hpp_pkg::HPP_GAP:  if (cnt_done) next_state = byte_idx ? hpp_pkg::HPP_IDLE : hpp_pkg::HPP_ACT;
      default:           next_state = hpp_pkg::HPP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state    <= hpp_pkg::HPP_IDLE;
      cnt      <= '0;
      byte_idx <= 1'b0;
      dir_read <= 1'b1;
      tx_word  <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == hpp_pkg::HPP_IDLE && next_state == hpp_pkg::HPP_ACT)
      begin
        byte_idx <= 1'b0;
        dir_read <= start_read;
        tx_word  <= hwdata[15:0];
      end
      if (state == hpp_pkg::HPP_GAP && cnt_done)
        byte_idx <= 1'b1;
      if (next_state == hpp_pkg::HPP_ACT && state != hpp_pkg::HPP_ACT)
        cnt <= CNT_W'(hpp_pkg::STROBE_CYC - 1);
      else if (next_state == hpp_pkg::HPP_GAP && state != hpp_pkg::HPP_GAP)
        cnt <= CNT_W'(hpp_pkg::GAP_CYC - 1);
      else if (!cnt_done)
        cnt <= cnt - 1'b1;
    end
  end

  // ----------------------------------------
  // Received word
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_word  <= 16'h0000;
      rx_valid <= 1'b0;
    end
    else
    begin
      if (state == hpp_pkg::HPP_ACT && cnt_done && dir_read)
      begin
        if (byte_idx)
          rx_word[7:0] <= in_s2[7:0];
        else
          rx_word[15:8] <= in_s2[7:0];
      end
      if (state == hpp_pkg::HPP_GAP && cnt_done && byte_idx && dir_read)
        rx_valid <= 1'b1;
      else if (rx_taken)
        rx_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic act_next;

  assign act_next = (next_state == hpp_pkg::HPP_ACT);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.host_select_n       <= 1'b1;
      link.host_read_strobe_n  <= 1'b1;
      link.host_write_strobe_n <= 1'b1;
      link.host_byte_out       <= 8'h00;
      link.host_byte_oe        <= 1'b0;
    end
    else
    begin
      link.host_select_n <= !act_next;
      if (ctrl[hpp_pkg::CTRL_SHARED])
      begin
        link.host_read_strobe_n  <= act_next ~^ ctrl[hpp_pkg::CTRL_DS_HIGH];
        link.host_write_strobe_n <= (state == hpp_pkg::HPP_IDLE) ? start_read || !start_write : dir_read;
      end
      else
      begin
        link.host_read_strobe_n  <= !(act_next && (busy ? dir_read : start_read));
        link.host_write_strobe_n <= !(act_next && (busy ? !dir_read : start_write));
      end
      link.host_byte_oe  <= act_next && (busy ? !dir_read : start_write);
      link.host_byte_out <= (busy ? (byte_idx || state == hpp_pkg::HPP_GAP) : 1'b0)
                            ? tx_word[7:0] : (busy ? tx_word[15:8] : hwdata[15:8]);
    end
  end
endmodule

// ==== testbench/hpp_sva.sv ====
// Checker for the byte link between the host and device ends
`timescale 1ns/1ps
module hpp_sva
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Link
  input wire logic       host_select_n,
  input wire logic       host_read_strobe_n,
  input wire logic       host_write_strobe_n,
  input wire logic       host_byte_oe,
  input wire logic [7:0] dev_byte_out,
  input wire logic       dev_byte_oe,
  input wire logic       handshake_status_out,
  // Configuration
  input wire logic       cfg_shared_mode,
  input wire logic       cfg_ds_active_high,
  input wire logic       cfg_hs_active_high
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic       ds_on;
  logic       rd_act;
  logic       wr_act;
  logic       hs_q;
  logic       hs_on;
  logic [3:0] since_acc;
  logic [3:0] since_rd;
  assign ds_on  = cfg_ds_active_high ? host_read_strobe_n : !host_read_strobe_n;
  assign rd_act = !host_select_n && (cfg_shared_mode ? ds_on && host_write_strobe_n : !host_read_strobe_n);
  assign wr_act = !host_select_n && (cfg_shared_mode ? ds_on && !host_write_strobe_n : !host_write_strobe_n);
  assign hs_on  = handshake_status_out == hs_q;
  always_ff @(posedge clk)
  begin
    hs_q <= cfg_hs_active_high;
  end
  always_ff @(posedge clk)
  begin
    if (!resetn || rd_act || wr_act)
      since_acc <= 4'h0;
    else if (since_acc != 4'hf)
      since_acc <= since_acc + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    if (!resetn || rd_act)
      since_rd <= 4'h0;
    else if (since_rd != 4'hf)
      since_rd <= since_rd + 4'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_rd_held;
    rd_act [*4];
  endsequence
  sequence s_wr_held;
    wr_act [*4];
  endsequence
  sequence s_idle;
    host_select_n [*5];
  endsequence
  a_deselect_release:
    assert property (s_idle |-> !dev_byte_oe) else $error("Bus driven while deselected");
  a_no_bus_clash:
    assert property (!(dev_byte_oe && host_byte_oe)) else $error("Both ends drive the bus");
  a_read_drives_bus:
    assert property (s_rd_held |-> dev_byte_oe) else $error("Read not answered");
  a_write_leaves_bus:
    assert property (s_wr_held |-> !dev_byte_oe) else $error("Device drives during write");
  a_read_byte_hold:
    assert property (s_rd_held ##1 rd_act |-> $stable(dev_byte_out)) else $error("Read byte moved");
  a_drive_needs_read:
    assert property (dev_byte_oe |-> since_rd <= 4'h5) else $error("Drive without read");
  a_hs_after_end:
    assert property ($rose(hs_on) |-> since_acc <= 4'h8) else $error("Handshake rose outside access end");
  a_host_byte_min:
    assert property ($fell(host_select_n) |-> !host_select_n [*3]) else $error("Host access too short");
endmodule

// ==== testbench/tb_top.sv ====
// Testbench joining the host and device ends and driving both user sides
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        cfg_shared_mode;
  logic        cfg_ds_active_high;
  logic        cfg_hs_active_high;
  logic        tx_write;
  logic [15:0] tx_wdata;
  logic        rx_read;
  logic [15:0] rx_rdata;
  logic [15:0] port_status;
  logic [15:0] wr_bytes;
  logic [15:0] rd_bytes;
  logic [7:0]  cur_w;
  logic [7:0]  cur_r;
  logic        prev_hoe = 1'b0;
  logic        prev_doe = 1'b0;
  logic [31:0] rd;
  logic [2:0]  modes [5] = '{3'h4, 3'h1, 3'h3, 3'h7, 3'h4};
  int          err_count;
  int          num_checks;
  hpp_if link ();
  hpp_device u_hpp_device (.clk(clk), .resetn(resetn), .link(link), .cfg_shared_mode(cfg_shared_mode),
    .cfg_ds_active_high(cfg_ds_active_high), .cfg_hs_active_high(cfg_hs_active_high), .tx_write(tx_write),
    .tx_wdata(tx_wdata), .rx_read(rx_read), .rx_rdata(rx_rdata), .port_status(port_status));
  hpp_host u_hpp_host (.clk(clk), .resetn(resetn), .link(link), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  hpp_sva u_hpp_sva (.clk(clk), .resetn(resetn), .host_select_n(link.host_select_n),
    .host_read_strobe_n(link.host_read_strobe_n), .host_write_strobe_n(link.host_write_strobe_n),
    .host_byte_oe(link.host_byte_oe), .dev_byte_out(link.dev_byte_out), .dev_byte_oe(link.dev_byte_oe),
    .handshake_status_out(link.handshake_status_out), .cfg_shared_mode(cfg_shared_mode),
    .cfg_ds_active_high(cfg_ds_active_high), .cfg_hs_active_high(cfg_hs_active_high));
  always #4 clk = ~clk;
  // Collects the bytes of each word as seen on the wire
  always @(posedge clk)
  begin
    prev_hoe <= link.host_byte_oe;
    prev_doe <= link.dev_byte_oe;
    if (link.host_byte_oe)
      cur_w <= link.host_byte_bus;
    if (link.dev_byte_oe)
      cur_r <= link.host_byte_bus;
    if (prev_hoe && !link.host_byte_oe)
      wr_bytes <= {wr_bytes[7:0], cur_w};
    if (prev_doe && !link.dev_byte_oe)
      rd_bytes <= {rd_bytes[7:0], cur_r};
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= hpp_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask
  task automatic host_wait();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[hpp_pkg::STAT_BUSY] !== 1'b0 && n < 200)
    begin
      ahb(1'b0, hpp_pkg::REG_STATUS, 32'h0);
      n++;
    end
    chk(rd[hpp_pkg::STAT_BUSY], 1'b0, "host idle");
  endtask
  task automatic wait_ps(input int b, input logic v);
    int n;
    n = 0;
    while (port_status[b] !== v && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(port_status[b], v, "port status bit");
  endtask
  task automatic host_send(input logic [15:0] w);
    ahb(1'b1, hpp_pkg::REG_TXDATA, {16'h0, w});
    host_wait();
    chk(wr_bytes, w, "write bytes on wire");
  endtask
  task automatic host_recv(input logic [15:0] w);
    ahb(1'b1, hpp_pkg::REG_CMD, 32'h1);
    host_wait();
    chk(rd[hpp_pkg::STAT_RX_VALID], 1'b1, "rx word ready");
    ahb(1'b0, hpp_pkg::REG_RXDATA, 32'h0);
    chk(rd, {16'h0, w}, "host read word");
    chk(rd_bytes, w, "read bytes on wire");
  endtask
  task automatic dev_push(input logic [15:0] w);
    @(posedge clk);
    tx_write <= 1'b1;
    tx_wdata <= w;
    @(posedge clk);
    tx_write <= 1'b0;
  endtask
  task automatic dev_pop(input logic [15:0] w);
    wait_ps(hpp_pkg::ST_RX_NEMPT, 1'b1);
    chk(rx_rdata, w, "device rx word");
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    chk(port_status, 16'h0800, "status after reset");
    chk(link.handshake_status_out, 1'b0, "handshake after reset");
    chk(hresp, 1'b0, "okay response");
    ahb(1'b0, hpp_pkg::REG_CTRL, 32'h0);
    chk(rd, {29'h0, hpp_pkg::CTRL_RESET}, "control reset value");
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask
  task automatic t_mode(input logic [2:0] c, input logic [15:0] w);
    dev_push(w);
    repeat (4) @(posedge clk);
    cfg_shared_mode    <= c[hpp_pkg::CTRL_SHARED];
    cfg_ds_active_high <= c[hpp_pkg::CTRL_DS_HIGH];
    cfg_hs_active_high <= c[hpp_pkg::CTRL_HS_HIGH];
    ahb(1'b1, hpp_pkg::REG_CTRL, {29'h0, c});
    host_recv(w);
    wait_ps(hpp_pkg::ST_TX_EMPTY, 1'b1);
    chk(link.handshake_status_out, c[hpp_pkg::CTRL_HS_HIGH], "handshake level");
    ahb(1'b0, hpp_pkg::REG_STATUS, 32'h0);
    chk(rd[hpp_pkg::STAT_HS], 1'b1, "host sees handshake");
    host_send(~w);
    dev_pop(~w);
  endtask
  task automatic t_tx_full();
    for (int i = 0; i <= hpp_pkg::FIFO_DEPTH; i++)
      dev_push(16'h0100 + 16'(i));
    repeat (2) @(posedge clk);
    chk(port_status[hpp_pkg::ST_TX_NFULL], 1'b0, "tx full");
    for (int i = 0; i < hpp_pkg::FIFO_DEPTH; i++)
      host_recv(16'h0100 + 16'(i));
    wait_ps(hpp_pkg::ST_TX_EMPTY, 1'b1);
    chk(port_status[hpp_pkg::ST_TX_NFULL], 1'b1, "tx has room");
  endtask
  task automatic t_rx_full();
    dev_push(16'h3c3c);
    repeat (2) @(posedge clk);
    chk(link.handshake_status_out, 1'b0, "handshake idle");
    for (int i = 0; i < hpp_pkg::FIFO_DEPTH; i++)
      host_send(16'h2000 + 16'(i));
    wait_ps(hpp_pkg::ST_RX_FULL, 1'b1);
    chk(link.handshake_status_out, 1'b1, "handshake on rx full");
    for (int i = 0; i < hpp_pkg::FIFO_DEPTH; i++)
      dev_pop(16'h2000 + 16'(i));
    host_recv(16'h3c3c);
    chk(port_status, 16'h0802, "status after drain");
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    {cfg_shared_mode, cfg_ds_active_high} = 2'h0;
    cfg_hs_active_high = 1'b1;
    {tx_write, tx_wdata, rx_read} = '0;
    err_count = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    foreach (modes[i])
      t_mode(modes[i], 16'hc35a ^ (16'h1111 * 16'(i)));
    t_tx_full();
    t_rx_full();
    print_verdict();
  end
  initial
  begin
    #500000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
